// >>> ipr_pkg.sv
// package: register map, field layout and reset values of the priority bank
package ipr_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int IPR_NUM_REGS = 8;
   localparam int IPR_FIELDS = 4;
   localparam int IPR_FW = 3;
   localparam int IPR_SLOTS = IPR_NUM_REGS * IPR_FIELDS;
   localparam int IPR_AW = 8;

   localparam logic [IPR_AW-1:0] IPR_OFS_CTRL2 = 8'h00;
   localparam logic [IPR_AW-1:0] IPR_OFS_CTRL3 = 8'h04;
   localparam logic [IPR_AW-1:0] IPR_OFS_CTRL4 = 8'h08;
   localparam logic [IPR_AW-1:0] IPR_OFS_CTRL5 = 8'h0c;
   localparam logic [IPR_AW-1:0] IPR_OFS_CTRL6 = 8'h10;
   localparam logic [IPR_AW-1:0] IPR_OFS_CTRL7 = 8'h14;
   localparam logic [IPR_AW-1:0] IPR_OFS_CTRL8 = 8'h18;
   localparam logic [IPR_AW-1:0] IPR_OFS_CTRL9 = 8'h1c;
   localparam logic [IPR_AW-1:0] IPR_OFS [IPR_NUM_REGS] = '{
      IPR_OFS_CTRL2, IPR_OFS_CTRL3, IPR_OFS_CTRL4, IPR_OFS_CTRL5,
      IPR_OFS_CTRL6, IPR_OFS_CTRL7, IPR_OFS_CTRL8, IPR_OFS_CTRL9};
   localparam logic [1:0] IPR_WORD_LSB = 2'h0;

   // ------------------------------------------------------------
   // field layout: fields at 14-12, 10-8, 6-4, 2-0
   // ------------------------------------------------------------
   localparam int IPR_FIELD_STRIDE = 4;
   localparam logic [15:0] IPR_IMPL_MASK [IPR_NUM_REGS] = '{
      16'h7777, 16'h0777, 16'h7777, 16'h7707,
      16'h7777, 16'h7777, 16'h7777, 16'h0007};
   localparam logic [15:0] IPR_RESET_PATTERN = 16'h4444;
   localparam logic [IPR_FW-1:0] IPR_FIELD_RESET = 3'h4;
   localparam logic [IPR_FW-1:0] IPR_FIELD_OFF = 3'h0;
   localparam logic [IPR_FW-1:0] IPR_FIELD_TOP = 3'h7;

   // can sources: event and receive fields of priority_control_8
   localparam int IPR_CAN_REG = 6;
   localparam logic [IPR_FIELDS-1:0] IPR_CAN_FIELDS = 4'hc;

   // ------------------------------------------------------------
   // bus responses
   // ------------------------------------------------------------
   localparam logic [1:0] IPR_RESP_OKAY = 2'h0;
   localparam logic [1:0] IPR_RESP_SLVERR = 2'h2;

endpackage

// >>> ipr_regs.sv
// module: interrupt priority register bank behind an axi4-lite slave
`timescale 1ns/1ps
module ipr_regs
   import ipr_pkg::*;
#(
   parameter bit CAN_PRESENT = 1'b1
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic [IPR_AW-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [IPR_AW-1:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [IPR_SLOTS*IPR_FW-1:0] o_slot_level,
   output logic [IPR_SLOTS-1:0] o_slot_active
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [IPR_NUM_REGS:0] decode(
      input logic [IPR_AW-1:0] addr);
      logic [IPR_NUM_REGS:0] hit;
      hit = '0;
      for (int k = 0; k < IPR_NUM_REGS; k++) begin
         if ({addr[IPR_AW-1:2], IPR_WORD_LSB} == IPR_OFS[k]) begin
            hit[k] = 1'b1;
         end
      end
      hit[IPR_NUM_REGS] = (hit[IPR_NUM_REGS-1:0] != '0);
      return hit;
   endfunction

   function automatic logic [2:0] index_of(input logic [IPR_NUM_REGS:0] hit);
      logic [2:0] idx;
      idx = '0;
      for (int k = 0; k < IPR_NUM_REGS; k++) begin
         if (hit[k]) begin
            idx = 3'(k);
         end
      end
      return idx;
   endfunction

   // ------------------------------------------------------------
   // write channel capture
   // ------------------------------------------------------------
   logic aw_held_reg;
   logic w_held_reg;
   logic [IPR_AW-1:0] aw_addr_reg;
   logic [15:0] w_data_reg;
   logic [1:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic do_write;
   logic [IPR_NUM_REGS:0] wr_hit;
   logic [2:0] wr_idx;
   logic [15:0] pri_reg [IPR_NUM_REGS];

   // readies drop with the clock enable so no beat is lost while frozen
   assign o_s_axi_awready = i_clk_en && !aw_held_reg && !bvalid_reg;
   assign o_s_axi_wready = i_clk_en && !w_held_reg && !bvalid_reg;
   assign do_write = i_clk_en && aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_hit = decode(aw_addr_reg);
   assign wr_idx = index_of(wr_hit);

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (i_clk_en) begin
         if (o_s_axi_awready && i_s_axi_awvalid) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= i_s_axi_awaddr;
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         w_held_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (i_clk_en) begin
         if (o_s_axi_wready && i_s_axi_wvalid) begin
            w_held_reg <= 1'b1;
            w_data_reg <= i_s_axi_wdata[15:0];
            w_strb_reg <= i_s_axi_wstrb[1:0];
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= IPR_RESP_OKAY;
      end else if (i_clk_en) begin
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit[IPR_NUM_REGS] ? IPR_RESP_OKAY : IPR_RESP_SLVERR;
         end else if (i_s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // a frozen slave shows no answer, so no beat is taken while it stands
   assign o_s_axi_bvalid = bvalid_reg && i_clk_en;
   assign o_s_axi_bresp = bresp_reg;

   // ------------------------------------------------------------
   // priority registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int k = 0; k < IPR_NUM_REGS; k++) begin
            // every implemented field starts at level 4
            pri_reg[k] <= IPR_RESET_PATTERN & IPR_IMPL_MASK[k];
         end
      end else if (i_clk_en && do_write && wr_hit[IPR_NUM_REGS]) begin
         // byte lanes above the 16-bit word carry nothing
         for (int b = 0; b < 2; b++) begin
            if (w_strb_reg[b]) begin
               pri_reg[wr_idx][b*8 +: 8] <=
                  w_data_reg[b*8 +: 8] & IPR_IMPL_MASK[wr_idx][b*8 +: 8];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   logic rvalid_reg;
   logic [15:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [2:0] rd_idx_reg;
   logic [IPR_NUM_REGS:0] rd_hit;

   assign o_s_axi_arready = i_clk_en && !rvalid_reg;
   assign rd_hit = decode(i_s_axi_araddr);

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= IPR_RESP_OKAY;
         rd_idx_reg <= '0;
      end else if (i_clk_en) begin
         if (o_s_axi_arready && i_s_axi_arvalid) begin
            rvalid_reg <= 1'b1;
            rd_idx_reg <= index_of(rd_hit);
            if (rd_hit[IPR_NUM_REGS]) begin
               rdata_reg <= pri_reg[index_of(rd_hit)];
               rresp_reg <= IPR_RESP_OKAY;
            end else begin
               rdata_reg <= '0;
               rresp_reg <= IPR_RESP_SLVERR;
            end
         end else if (i_s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign o_s_axi_rvalid = rvalid_reg && i_clk_en;
   assign o_s_axi_rresp = rresp_reg;
   assign o_s_axi_rdata = {16'h0000, rdata_reg};

   // ------------------------------------------------------------
   // per-source levels
   // ------------------------------------------------------------
   // slot 4*r+f is field f (f=0 at bits 2-0) of register r
   always_comb begin
      o_slot_level = '0;
      o_slot_active = '0;
      for (int r = 0; r < IPR_NUM_REGS; r++) begin
         for (int f = 0; f < IPR_FIELDS; f++) begin
            o_slot_level[(r*IPR_FIELDS+f)*IPR_FW +: IPR_FW] =
               pri_reg[r][f*IPR_FIELD_STRIDE +: IPR_FW];
            // a variant without can forces its sources off
            if (!CAN_PRESENT && r == IPR_CAN_REG && IPR_CAN_FIELDS[f]) begin
               o_slot_level[(r*IPR_FIELDS+f)*IPR_FW +: IPR_FW] = IPR_FIELD_OFF;
            end
            // level 0 never competes; 1..7 rank in binary order
            o_slot_active[r*IPR_FIELDS+f] =
               o_slot_level[(r*IPR_FIELDS+f)*IPR_FW +: IPR_FW]
               != IPR_FIELD_OFF;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic unimpl_set;
   always_comb begin
      unimpl_set = 1'b0;
      for (int k = 0; k < IPR_NUM_REGS; k++) begin
         if ((pri_reg[k] & ~IPR_IMPL_MASK[k]) != '0) begin
            unimpl_set = 1'b1;
         end
      end
   end

   sequence full_write_s;
      do_write && wr_hit[IPR_NUM_REGS] && w_strb_reg == 2'h3;
   endsequence

   sequence read_back_s;
      ##1 pri_reg[$past(wr_idx)] == ($past(w_data_reg)
         & IPR_IMPL_MASK[$past(wr_idx)]);
   endsequence

   top_level_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_slot_level[2:0] == IPR_FIELD_TOP |-> o_slot_active[0])
      else $error("level 7 source not active");

   low_level_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_slot_level[17:15] == pri_reg[1][6:4])
      else $error("converter level does not follow its field");

   lowest_on_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_slot_level[17:15] == 3'h1 |-> o_slot_active[5])
      else $error("level 1 source not active");

   disabled_src_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_slot_level[5:3] == IPR_FIELD_OFF |-> !o_slot_active[1])
      else $error("disabled source still active");

   unimpl_zero_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      !unimpl_set && o_s_axi_rdata[31:16] == '0)
      else $error("unimplemented bit is set");

   reset_level_a: assert property (
      @(posedge i_clk_sys)
      $fell(i_sys_rst) |-> o_slot_level[11:9] == IPR_FIELD_RESET
      && pri_reg[7] == (IPR_RESET_PATTERN & IPR_IMPL_MASK[7]))
      else $error("reset pattern not loaded");

   // unused slots 7, 13, 29-31 stay off; without can also 26 and 27
   reset_four_a: assert property (
      @(posedge i_clk_sys)
      $fell(i_sys_rst) |-> o_slot_level[2:0] == IPR_FIELD_RESET
      && o_slot_active == (CAN_PRESENT ? 32'h1fff_df7f : 32'h13ff_df7f))
      else $error("source not at level 4 after reset");

   field_pos_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_slot_level[11:9] == pri_reg[0][14:12])
      else $error("uart1 rx field misplaced");

   can_off_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      !CAN_PRESENT |-> o_slot_active[27:26] == 2'h0)
      else $error("can source active on a variant without can");

   dma3_only_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      rvalid_reg && rd_idx_reg == 3'h7 |-> rdata_reg[15:3] == '0)
      else $error("ninth register returns upper bits");

   reg3_top_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      rvalid_reg && rd_idx_reg == 3'h1 |-> rdata_reg[15:11] == '0)
      else $error("third register returns bits 15-11");

   write_back_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      full_write_s |-> read_back_s)
      else $error("written value not held");

   // a frozen slave keeps its answer, else the master would lose the beat
   write_hold_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      bvalid_reg && !i_clk_en |=> bvalid_reg && $stable(bresp_reg))
      else $error("write answer lost while frozen");

   read_hold_a: assert property (
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      rvalid_reg && !i_clk_en |=> rvalid_reg && $stable(rdata_reg))
      else $error("read answer lost while frozen");

endmodule

// >>> tb_top.sv
// testbench: priority bank reset, access, slot levels, bus errors, no-can
`timescale 1ns/1ps
module tb_top;
   import ipr_pkg::*;
   logic clk, rst, clk_en, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [IPR_AW-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [IPR_SLOTS*IPR_FW-1:0] lvl, lvl2;
   logic [IPR_SLOTS-1:0] act, act2;
   logic [15:0] mdl [IPR_NUM_REGS];
   // masks written out here so a wrong package table is caught
   logic [15:0] msk [8] = '{16'h7777, 16'h0777, 16'h7777, 16'h7707,
      16'h7777, 16'h7777, 16'h7777, 16'h0007};
   int n_mismatch, num_checks;

   ipr_regs #(.CAN_PRESENT(1'b1)) DUT (.i_clk_sys(clk), .i_sys_rst(rst),
      .i_clk_en(clk_en), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
      .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_slot_level(lvl),
      .o_slot_active(act));
   // twin without can: same bus traffic, only its slots are watched
   ipr_regs #(.CAN_PRESENT(1'b0)) DUT_NOCAN (.i_clk_sys(clk),
      .i_sys_rst(rst), .i_clk_en(clk_en), .i_s_axi_awaddr(awaddr),
      .i_s_axi_awvalid(awvalid), .o_s_axi_awready(), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(),
      .o_s_axi_bresp(), .o_s_axi_bvalid(), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(), .o_s_axi_rdata(), .o_s_axi_rresp(),
      .o_s_axi_rvalid(), .i_s_axi_rready(rready), .o_slot_level(lvl2),
      .o_slot_active(act2));

   // ------------------------------------------------------------
   // clock, enable and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      clk_en <= ($urandom % 4) != 0;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d,
      input logic [3:0] sb, output logic [1:0] r);
      awaddr <= a;
      wdata <= {d, d};
      wstrb <= sb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // each channel is released on its own handshake edge
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk_reg(input int i);
      logic [31:0] d;
      logic [1:0] r;
      rd(IPR_OFS[i], d, r);
      chk("rdata", d, {16'h0, mdl[i]});
      chk("rresp", r, IPR_RESP_OKAY);
   endtask

   // expected level of a slot; the can event and receive slots are off
   // on a variant without can
   function automatic logic [2:0] exp_lvl(input int s, input bit can);
      if (!can && s / 4 == 6 && s % 4 >= 2) begin
         return 3'h0;
      end
      return 3'(mdl[s / 4] >> (4 * (s % 4)));
   endfunction

   task automatic chk_all();
      logic [2:0] e;
      for (int i = 0; i < IPR_NUM_REGS; i++) chk_reg(i);
      for (int s = 0; s < IPR_SLOTS; s++) begin
         e = exp_lvl(s, 1'b1);
         chk("level", lvl[3*s+:3], e);
         chk("active", act[s], e != 3'h0);
         e = exp_lvl(s, 1'b0);
         chk("nocan level", lvl2[3*s+:3], e);
         chk("nocan active", act2[s], e != 3'h0);
      end
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) mdl[i] = 16'h4444 & msk[i];
      @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [15:0] d;
      logic [3:0] sb;
      logic [1:0] r;
      logic [31:0] q;
      int i;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, wstrb} = '0;
      void'($urandom(69761));
      do_reset();
      chk_all();
      $display("test reset values done");
      for (int c = 0; c < 8; c++) begin
         for (i = 0; i < 8; i++) begin
            // the gap bits 15, 11, 7 and 3 are always set in the written value
            wr(IPR_OFS[i], 16'(16'h1111 * c) | 16'h8888, 4'h3, r);
            chk("bresp", r, IPR_RESP_OKAY);
            mdl[i] = 16'(16'h1111 * c) & msk[i];
         end
         chk_all();
      end
      $display("test every code done");
      repeat (40) begin
         i = $urandom % 8;
         d = 16'($urandom);
         sb = 4'($urandom);
         wr(IPR_OFS[i], d, sb, r);
         if (sb[0]) mdl[i][7:0] = d[7:0] & msk[i][7:0];
         if (sb[1]) mdl[i][15:8] = d[15:8] & msk[i][15:8];
         chk_reg(i);
      end
      chk_all();
      $display("test random strobes done");
      wr(8'h20, 16'h7777, 4'h3, r);
      chk("unmapped bresp", r, IPR_RESP_SLVERR);
      rd(8'h24, q, r);
      chk("unmapped rdata", q, 32'h0);
      chk("unmapped rresp", r, IPR_RESP_SLVERR);
      chk_all();
      $display("test unmapped done");
      do_reset();
      chk_all();
      $display("test second reset done");
      end_sim();
   end
endmodule
